// ===== common/sepf_pkg.sv
// package for the secure element host front end: i2c slave, frame layer, power modes
// assumes a single 100 MHz clock; all pin inputs are synchronised before use
package sepf_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ         = 100;
	localparam int SLEEP_IDLE_MS   = 312;
	localparam int FRAME_WAIT_MS   = 320;
	localparam int DEEP_SLEEP_US   = 500;
	localparam int STRAP_HOLD_US   = 500;
	localparam int SLEEP_IDLE_CYC  = SLEEP_IDLE_MS * 1000 * CLK_MHZ;
	localparam int FRAME_WAIT_CYC  = FRAME_WAIT_MS * 1000 * CLK_MHZ;
	localparam int DEEP_SLEEP_CYC  = DEEP_SLEEP_US * CLK_MHZ;
	localparam int STRAP_HOLD_CYC  = STRAP_HOLD_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// addressing and framing
	// ----------------------------------------------------------------
	localparam logic [6:0] ADDR_STRAP_LO        = 7'h48;
	localparam logic [6:0] ADDR_STRAP_HI        = 7'h49;
	localparam int         MAX_HOST_FRAME_LEN   = 255;
	localparam int         MAX_DEVICE_FRAME_LEN = 252;
	localparam logic [7:0] EDC_SEED             = 8'h00;
	localparam logic [7:0] PAD_BYTE             = 8'hff;
	localparam logic [7:0] NO_REPLY_LEN         = 8'h00;
	localparam logic [3:0] BYTE_BITS            = 4'h8;

	// ----------------------------------------------------------------
	// carriers and states
	// ----------------------------------------------------------------
	typedef struct packed {
		logic scl;
		logic sda;
	} i2c_lines_t;

	typedef struct packed {
		logic       rst_n;
		logic       addr_sel;
		logic       iface_en;
		i2c_lines_t lines;
	} pins_t;

	typedef struct packed {
		logic [7:0] data;
		logic       valid;
		logic       last;
	} rx_beat_t;

	typedef struct packed {
		logic ok;
		logic err;
	} frame_check_t;

	typedef enum logic [2:0] {SLV_IDLE, SLV_ADDR, SLV_ADDR_ACK, SLV_WR, SLV_WR_ACK, SLV_RD, SLV_RD_ACK} slv_state_t;
	typedef enum logic [1:0] {PWR_BOOT, PWR_AWAKE, PWR_SLEEP, PWR_DEEP} pwr_state_t;
	typedef enum logic [1:0] {RXP_IDLE, RXP_LEN, RXP_DATA, RXP_EDC} rx_phase_t;
	typedef enum logic [1:0] {TXP_LEN, TXP_DATA, TXP_EDC, TXP_PAD} tx_phase_t;

	// error detection code: running xor, a good frame folds to zero
	function automatic logic [7:0] edc_next(input logic [7:0] acc, input logic [7:0] b);
		return acc ^ b;
	endfunction : edc_next

endpackage : sepf_pkg

// ===== rtl/i2c_byte_slave.sv
// i2c slave byte engine: start/stop detection, address match, byte shift in and out
// assumes synchronised scl/sda; frozen while step is low, except that clr still clears it
module i2c_byte_slave (
	input  wire logic           clk,
	input  wire logic           nrst,
	input  wire logic           step,
	input  wire logic           clr,
	input  sepf_pkg::i2c_lines_t lines,
	input  wire logic [6:0]     own_addr,
	input  wire logic [7:0]     tx_byte,
	output logic                sda_low,
	output logic                wr_sel,
	output logic                rd_sel,
	output logic                rx_stb,
	output logic [7:0]          rx_byte,
	output logic                tx_take,
	output logic                stop_seen
);
	import sepf_pkg::*;

	slv_state_t st_r;
	i2c_lines_t prev_r;
	logic [7:0] sh_r;
	logic [3:0] cnt_r;
	logic       rw_r;
	logic       scl_rise, scl_fall, start_c, stop_c;

	// line events, seen only while running; a frozen prev keeps a wake edge visible
	assign scl_rise = step & lines.scl & ~prev_r.scl;
	assign scl_fall = step & ~lines.scl & prev_r.scl;
	assign start_c  = step & prev_r.scl & lines.scl & prev_r.sda & ~lines.sda;
	assign stop_c   = step & prev_r.scl & lines.scl & ~prev_r.sda & lines.sda;

	// previous line levels
	always_ff @(posedge clk) begin
		if (!nrst)
			prev_r <= '1;
		else if (step)
			prev_r <= lines;
	end

	// slave only: never drives scl, bit timing follows the master's clock
	always_ff @(posedge clk) begin
		if (!nrst || clr) begin
			st_r      <= SLV_IDLE;
			sda_low   <= 1'b0;
			sh_r      <= 8'h00;
			cnt_r     <= 4'h0;
			rw_r      <= 1'b0;
			rx_byte   <= 8'h00;
			wr_sel    <= 1'b0;
			rd_sel    <= 1'b0;
			rx_stb    <= 1'b0;
			tx_take   <= 1'b0;
			stop_seen <= 1'b0;
		end else begin
			wr_sel    <= 1'b0;
			rd_sel    <= 1'b0;
			rx_stb    <= 1'b0;
			tx_take   <= 1'b0;
			stop_seen <= 1'b0;
			if (start_c) begin
				st_r    <= SLV_ADDR;
				cnt_r   <= 4'h0;
				sda_low <= 1'b0;
			end else if (stop_c) begin
				st_r      <= SLV_IDLE;
				sda_low   <= 1'b0;
				stop_seen <= 1'b1;
			end else if (scl_rise) begin
				unique case (st_r)
					SLV_ADDR, SLV_WR: begin
						sh_r  <= {sh_r[6:0], lines.sda};
						cnt_r <= cnt_r + 4'h1;
					end
					SLV_RD:     cnt_r <= cnt_r + 4'h1;
					SLV_RD_ACK: if (lines.sda) st_r <= SLV_IDLE; // master nack ends the read
					SLV_IDLE, SLV_ADDR_ACK, SLV_WR_ACK: ;
				endcase
			end else if (scl_fall) begin
				unique case (st_r)
					SLV_ADDR: if (cnt_r == BYTE_BITS) begin
						if (sh_r[7:1] == own_addr) begin
							sda_low <= 1'b1;
							rw_r    <= sh_r[0];
							wr_sel  <= ~sh_r[0];
							rd_sel  <= sh_r[0];
							st_r    <= SLV_ADDR_ACK;
						end else
							st_r <= SLV_IDLE;
					end
					SLV_ADDR_ACK, SLV_RD_ACK: begin
						cnt_r <= 4'h0;
						if (rw_r) begin
							sh_r    <= tx_byte;
							sda_low <= ~tx_byte[7];
							tx_take <= 1'b1;
							st_r    <= SLV_RD;
						end else begin
							sda_low <= 1'b0;
							st_r    <= SLV_WR;
						end
					end
					SLV_WR: if (cnt_r == BYTE_BITS) begin
						sda_low <= 1'b1;
						rx_byte <= sh_r;
						rx_stb  <= 1'b1;
						st_r    <= SLV_WR_ACK;
					end
					SLV_WR_ACK: begin
						sda_low <= 1'b0;
						cnt_r   <= 4'h0;
						st_r    <= SLV_WR;
					end
					SLV_RD: if (cnt_r == BYTE_BITS) begin
						sda_low <= 1'b0;
						st_r    <= SLV_RD_ACK;
					end else begin
						sh_r    <= {sh_r[6:0], 1'b0};
						sda_low <= ~sh_r[6];
					end
					SLV_IDLE: ;
				endcase
			end
		end
	end

endmodule : i2c_byte_slave

// ===== rtl/secure_element_i2c_power_front.sv
// host front end of a secure element: i2c slave, frame layer with edc, strap sampling,
// automatic sleep and reset-pin deep sleep
// assumes all pins are asynchronous to CLK; the core consumes RX and supplies the reply
module secure_element_i2c_power_front
	import sepf_pkg::*;
#(
	parameter int CNT_W             = 25,
	parameter int SLEEP_IDLE_CYCLES = SLEEP_IDLE_CYC,
	parameter int FRAME_WAIT_CYCLES = FRAME_WAIT_CYC,
	parameter int DEEP_SLEEP_CYCLES = DEEP_SLEEP_CYC,
	parameter int STRAP_HOLD_CYCLES = STRAP_HOLD_CYC,
	parameter int MAX_HOST_LEN      = MAX_HOST_FRAME_LEN,
	parameter int MAX_DEV_LEN       = MAX_DEVICE_FRAME_LEN
) (
	input  wire logic            CLK,
	input  wire logic            NRST,
	input  wire logic            SCL_PIN,
	input  wire logic            SDA_PIN,
	output logic                 SDA_OUT,
	output logic                 SDA_OE_N,
	input  wire logic            IFACE_ENABLE_STRAP,
	input  wire logic            ADDR_SELECT_STRAP,
	input  wire logic            RESET_PIN_N,
	output logic                 CORE_CLK_EN,
	output logic                 CORE_POWER_EN,
	output logic                 ASLEEP,
	output logic                 DEEP_ASLEEP,
	output logic                 IFACE_ACTIVE,
	output sepf_pkg::rx_beat_t   RX,
	output sepf_pkg::frame_check_t FRAME_CHK,
	input  wire logic            REPLY_PENDING,
	input  wire logic [7:0]      REPLY_LEN,
	input  wire logic [7:0]      TX_DATA,
	input  wire logic            TX_VALID,
	output logic                 TX_READY,
	output logic                 FWT_EXPIRED
);
	import sepf_pkg::*;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (CNT_W < 4 || CNT_W > 31) begin : g_bad_w
		$error("counter width out of range");
	end
	if (SLEEP_IDLE_CYCLES < 2 || FRAME_WAIT_CYCLES < 2 || DEEP_SLEEP_CYCLES < 2 || STRAP_HOLD_CYCLES < 2 ||
	    SLEEP_IDLE_CYCLES >= (1 << CNT_W) || FRAME_WAIT_CYCLES >= (1 << CNT_W) ||
	    DEEP_SLEEP_CYCLES >= (1 << CNT_W) || STRAP_HOLD_CYCLES >= (1 << CNT_W)) begin : g_bad_cnt
		$error("timing count does not fit the counters");
	end
	if (MAX_HOST_LEN < 1 || MAX_HOST_LEN > 255 || MAX_DEV_LEN < 1 || MAX_DEV_LEN > 255) begin : g_bad_len
		$error("frame length limit out of range");
	end

	localparam logic [CNT_W-1:0] IDLE_LAST  = CNT_W'(SLEEP_IDLE_CYCLES - 1);
	localparam logic [CNT_W-1:0] FWT_LAST   = CNT_W'(FRAME_WAIT_CYCLES - 1);
	localparam logic [CNT_W-1:0] DEEP_LIMIT = CNT_W'(DEEP_SLEEP_CYCLES);
	localparam logic [CNT_W-1:0] STRAP_LAST = CNT_W'(STRAP_HOLD_CYCLES - 1);
	localparam logic [7:0]       HOST_MAX   = 8'(MAX_HOST_LEN);
	localparam logic [7:0]       DEV_MAX    = 8'(MAX_DEV_LEN);

	// reply length never beyond the outgoing limit
	function automatic logic [7:0] clip_len(input logic [7:0] len);
		return (len > DEV_MAX) ? DEV_MAX : len;
	endfunction : clip_len

	pins_t            meta_r, sync_r;
	i2c_lines_t       prev_r;
	logic             rst_low, sda_fall, line_edge, deep_hit;
	logic [CNT_W-1:0] strap_cnt_r, rlow_cnt_r, idle_cnt_r, fwt_cnt_r;
	logic             strap_done_r, iface_active_r;
	logic [6:0]       own_addr_r;
	pwr_state_t       pwr_r, pwr_nxt;
	logic             eng_step;
	logic             sda_low, wr_sel, rd_sel, rx_stb, tx_take, stop_seen;
	logic [7:0]       rx_byte;
	rx_phase_t        rxp_r;
	logic [7:0]       rx_len_r, rx_cnt_r, rx_acc_r, rx_acc_nxt;
	tx_phase_t        txp_r;
	logic [7:0]       tx_next_r, tx_left_r, tx_acc_r, tx_acc_nxt;
	logic             fwt_run_r;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	// two flops per pin; only the second stage is read
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			meta_r <= '1;
			sync_r <= '1;
			prev_r <= '1;
		end else begin
			meta_r <= {RESET_PIN_N, ADDR_SELECT_STRAP, IFACE_ENABLE_STRAP, SCL_PIN, SDA_PIN};
			sync_r <= meta_r;
			prev_r <= sync_r.lines;
		end
	end

	assign rst_low   = ~sync_r.rst_n;
	assign sda_fall  = prev_r.sda & ~sync_r.lines.sda;
	assign line_edge = (prev_r != sync_r.lines);
	assign deep_hit  = rst_low && (rlow_cnt_r == DEEP_LIMIT);

	// ----------------------------------------------------------------
	// strap sampling after power-up
	// ----------------------------------------------------------------
	// wait out the hold time, then capture the interface configuration
	always_ff @(posedge CLK) begin
		if (!NRST || pwr_r == PWR_DEEP) begin
			strap_cnt_r    <= '0;
			strap_done_r   <= 1'b0;
			iface_active_r <= 1'b0;
			own_addr_r     <= ADDR_STRAP_LO;
		end else if (!strap_done_r) begin
			if (strap_cnt_r == STRAP_LAST) begin
				strap_done_r   <= 1'b1;
				iface_active_r <= ~(~sync_r.iface_en & ~sync_r.lines.scl & ~sync_r.lines.sda);
				own_addr_r     <= sync_r.addr_sel ? ADDR_STRAP_HI : ADDR_STRAP_LO;
			end else
				strap_cnt_r <= strap_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// reset pin and idle timers
	// ----------------------------------------------------------------
	// length of the current low pulse on the reset pin, saturating
	always_ff @(posedge CLK) begin
		if (!NRST || !rst_low)
			rlow_cnt_r <= '0;
		else if (rlow_cnt_r != DEEP_LIMIT)
			rlow_cnt_r <= rlow_cnt_r + 1'b1;
	end

	// quiet-line timer: restarts on any edge, runs only while awake
	always_ff @(posedge CLK) begin
		if (!NRST || pwr_r != PWR_AWAKE || line_edge)
			idle_cnt_r <= '0;
		else if (idle_cnt_r != IDLE_LAST)
			idle_cnt_r <= idle_cnt_r + 1'b1;
	end

	// ----------------------------------------------------------------
	// power state
	// ----------------------------------------------------------------
	// deep sleep wins over everything, then wake causes, then idle entry
	always_comb begin
		pwr_nxt = pwr_r;
		if (deep_hit)
			pwr_nxt = PWR_DEEP;
		else
			unique case (pwr_r)
				PWR_BOOT:  if (strap_done_r) pwr_nxt = PWR_AWAKE;
				PWR_AWAKE: if (!rst_low && idle_cnt_r == IDLE_LAST) pwr_nxt = PWR_SLEEP;
				PWR_SLEEP: if (sda_fall || rst_low) pwr_nxt = PWR_AWAKE;
				PWR_DEEP:  if (!rst_low) pwr_nxt = PWR_BOOT;
			endcase
	end

	// state and the sleep, clock and power outputs from the next state; IFACE_ACTIVE copies iface_active_r
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			pwr_r         <= PWR_BOOT;
			ASLEEP        <= 1'b0;
			DEEP_ASLEEP   <= 1'b0;
			CORE_CLK_EN   <= 1'b0;
			CORE_POWER_EN <= 1'b1;
			IFACE_ACTIVE  <= 1'b0;
		end else begin
			pwr_r         <= pwr_nxt;
			ASLEEP        <= (pwr_nxt == PWR_SLEEP);
			DEEP_ASLEEP   <= (pwr_nxt == PWR_DEEP);
			CORE_CLK_EN   <= (pwr_nxt == PWR_AWAKE);
			CORE_POWER_EN <= (pwr_nxt != PWR_DEEP);
			IFACE_ACTIVE  <= iface_active_r;
		end
	end

	// ----------------------------------------------------------------
	// i2c engine and pad
	// ----------------------------------------------------------------
	// engine frozen while asleep so its drive and state survive the nap
	assign eng_step = (pwr_r == PWR_AWAKE) && iface_active_r && !rst_low;

	i2c_byte_slave u_slave (
		.clk       (CLK),
		.nrst      (NRST),
		.step      (eng_step),
		.clr       (rst_low),
		.lines     (sync_r.lines),
		.own_addr  (own_addr_r),
		.tx_byte   (tx_next_r),
		.sda_low   (sda_low),
		.wr_sel    (wr_sel),
		.rd_sel    (rd_sel),
		.rx_stb    (rx_stb),
		.rx_byte   (rx_byte),
		.tx_take   (tx_take),
		.stop_seen (stop_seen)
	);

	// open-drain data pad; released in deep sleep
	always_ff @(posedge CLK) begin
		if (!NRST) begin
			SDA_OUT  <= 1'b0;
			SDA_OE_N <= 1'b1;
		end else begin
			SDA_OUT  <= 1'b0;
			SDA_OE_N <= ~(sda_low && pwr_nxt != PWR_DEEP);
		end
	end

	// ----------------------------------------------------------------
	// receive frame: length, data, edc
	// ----------------------------------------------------------------
	assign rx_acc_nxt = edc_next(rx_acc_r, rx_byte);

	// frames carry one payload mapping only; no binding negotiation
	always_ff @(posedge CLK) begin
		if (!NRST || rst_low) begin
			rxp_r     <= RXP_IDLE;
			rx_len_r  <= 8'h00;
			rx_cnt_r  <= 8'h00;
			rx_acc_r  <= EDC_SEED;
			RX        <= '0;
			FRAME_CHK <= '0;
		end else begin
			RX.valid  <= 1'b0;
			RX.last   <= 1'b0;
			FRAME_CHK <= '0;
			if (wr_sel) begin
				rxp_r    <= RXP_LEN;
				rx_acc_r <= EDC_SEED;
			end else if (rx_stb) begin
				rx_acc_r <= rx_acc_nxt;
				unique case (rxp_r)
					RXP_IDLE: FRAME_CHK.err <= 1'b1; // bytes past the frame
					RXP_LEN: begin
						rx_len_r <= rx_byte;
						rx_cnt_r <= 8'h00;
						if (rx_byte > HOST_MAX) begin
							FRAME_CHK.err <= 1'b1;
							rxp_r         <= RXP_IDLE;
						end else
							rxp_r <= (rx_byte == 8'h00) ? RXP_EDC : RXP_DATA;
					end
					RXP_DATA: begin
						RX.data  <= rx_byte;
						RX.valid <= 1'b1;
						RX.last  <= (rx_cnt_r + 8'h01 == rx_len_r);
						rx_cnt_r <= rx_cnt_r + 8'h01;
						if (rx_cnt_r + 8'h01 == rx_len_r)
							rxp_r <= RXP_EDC;
					end
					RXP_EDC: begin
						FRAME_CHK.ok  <= (rx_acc_nxt == 8'h00);
						FRAME_CHK.err <= (rx_acc_nxt != 8'h00);
						rxp_r         <= RXP_IDLE;
					end
				endcase
			end else if (stop_seen && (rxp_r == RXP_DATA || rxp_r == RXP_EDC)) begin
				FRAME_CHK.err <= 1'b1; // frame cut short
				rxp_r         <= RXP_IDLE;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit frame: length, data pulled from core, edc, pad
	// ----------------------------------------------------------------
	assign tx_acc_nxt = edc_next(tx_acc_r, tx_next_r);

	// next byte is always staged in tx_next_r ahead of the master's clock
	always_ff @(posedge CLK) begin
		if (!NRST || rst_low) begin
			txp_r     <= TXP_PAD;
			tx_next_r <= PAD_BYTE;
			tx_left_r <= 8'h00;
			tx_acc_r  <= EDC_SEED;
			TX_READY  <= 1'b0;
		end else if (rd_sel) begin
			txp_r     <= TXP_LEN;
			tx_next_r <= REPLY_PENDING ? clip_len(REPLY_LEN) : NO_REPLY_LEN;
			tx_left_r <= REPLY_PENDING ? clip_len(REPLY_LEN) : NO_REPLY_LEN;
			tx_acc_r  <= EDC_SEED;
			TX_READY  <= 1'b0;
		end else if (tx_take) begin
			tx_acc_r <= tx_acc_nxt;
			unique case (txp_r)
				TXP_LEN: if (tx_left_r == 8'h00) begin
					tx_next_r <= tx_acc_nxt;
					txp_r     <= TXP_EDC;
				end else begin
					TX_READY <= 1'b1;
					txp_r    <= TXP_DATA;
				end
				TXP_DATA: begin
					tx_left_r <= tx_left_r - 8'h01;
					if (tx_left_r == 8'h01) begin
						tx_next_r <= tx_acc_nxt;
						TX_READY  <= 1'b0;
						txp_r     <= TXP_EDC;
					end else
						TX_READY <= 1'b1;
				end
				TXP_EDC: begin
					tx_next_r <= PAD_BYTE;
					txp_r     <= TXP_PAD;
				end
				TXP_PAD: tx_next_r <= PAD_BYTE;
			endcase
		end else if (TX_READY && TX_VALID) begin
			tx_next_r <= TX_DATA;
			TX_READY  <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// frame waiting time
	// ----------------------------------------------------------------
	// runs from a good frame until the core has a reply or the host addresses the device
	always_ff @(posedge CLK) begin
		if (!NRST || rst_low) begin
			fwt_run_r   <= 1'b0;
			fwt_cnt_r   <= '0;
			FWT_EXPIRED <= 1'b0;
		end else if (FRAME_CHK.ok) begin
			fwt_run_r   <= 1'b1;
			fwt_cnt_r   <= '0;
			FWT_EXPIRED <= 1'b0;
		end else if (REPLY_PENDING || rd_sel || wr_sel) begin
			fwt_run_r <= 1'b0;
			if (wr_sel)
				FWT_EXPIRED <= 1'b0;
		end else if (fwt_run_r) begin
			if (fwt_cnt_r == FWT_LAST) begin
				FWT_EXPIRED <= 1'b1;
				fwt_run_r   <= 1'b0;
			end else
				fwt_cnt_r <= fwt_cnt_r + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	addr_select_a: assert property ($rose(strap_done_r) |->
		own_addr_r == ($past(sync_r.addr_sel) ? ADDR_STRAP_HI : ADDR_STRAP_LO))
		else $error("address does not follow select strap");
	iface_off_a: assert property (strap_done_r && !iface_active_r |-> SDA_OE_N && !eng_step)
		else $error("disabled interface touched the bus");
	sleep_entry_a: assert property (pwr_r == PWR_AWAKE && idle_cnt_r == IDLE_LAST && !rst_low && !deep_hit
		|=> ASLEEP && !CORE_CLK_EN)
		else $error("no sleep after idle time");
	clock_stop_a: assert property (ASLEEP |-> !CORE_CLK_EN && CORE_POWER_EN)
		else $error("core clock runs in sleep");
	pin_hold_a: assert property (ASLEEP && $past(ASLEEP) |-> $stable(SDA_OE_N))
		else $error("data pad changed during sleep");
	sda_wake_a: assert property (pwr_r == PWR_SLEEP && sda_fall && !deep_hit |=> !ASLEEP ##1 CORE_CLK_EN [*2])
		else $error("no wake on data falling edge");
	reset_wake_a: assert property (pwr_r == PWR_SLEEP && rst_low && !deep_hit |=> !ASLEEP)
		else $error("reset pin did not end sleep");
	deep_entry_a: assert property ($rose(rst_low) ##1 rst_low [*8] |-> !DEEP_ASLEEP)
		else $error("deep sleep too early");
	deep_hiz_a: assert property (deep_hit |=> DEEP_ASLEEP && SDA_OE_N && !CORE_POWER_EN)
		else $error("deep sleep not entered with pads released");
	deep_exit_a: assert property (pwr_r == PWR_DEEP && !rst_low |=> !DEEP_ASLEEP ##1 !strap_done_r)
		else $error("deep sleep not left on reset release");
	reply_clip_a: assert property (rd_sel && !rst_low |=> tx_left_r <= DEV_MAX && tx_next_r <= DEV_MAX)
		else $error("reply length above limit");
	edc_check_a: assert property (rxp_r == RXP_EDC && rx_stb && !wr_sel && !rst_low
		|=> FRAME_CHK.ok == ($past(rx_acc_nxt) == 8'h00) && FRAME_CHK.ok != FRAME_CHK.err)
		else $error("edc verdict wrong");
	fwt_a: assert property ($rose(FWT_EXPIRED) |-> $past(fwt_cnt_r) == FWT_LAST)
		else $error("frame waiting time wrong");
	idle_restart_a: assert property (line_edge |=> idle_cnt_r == '0)
		else $error("idle timer not restarted by line edge");

	sleep_wake_c: cover property (pwr_r == PWR_SLEEP ##1 pwr_r == PWR_AWAKE);
	deep_cycle_c: cover property (pwr_r == PWR_DEEP ##1 pwr_r == PWR_BOOT);
	good_frame_c: cover property (FRAME_CHK.ok);
	reply_byte_c: cover property (TX_READY && TX_VALID);

endmodule : secure_element_i2c_power_front

// ===== dv/i2c_host_model.sv
// host i2c master model: push-pull clock and open-drain data drivers, bit and byte tasks
// assumes the bench resolves the data wire and feeds it back on sda
module i2c_host_model (
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam real Q = 31.25; // quarter of the 125 ns bit period

	// --------------------------------
	// line control
	// --------------------------------
	// both lines released and steady outside frames
	initial begin
		scl = 1'b1;
		sda_drv = 1'b0;
	end

	task automatic start_c();
		sda_drv = 1'b0;
		#Q scl = 1'b1;
		#(2*Q) sda_drv = 1'b1;
		#(2*Q) scl = 1'b0;
		#Q;
	endtask : start_c

	task automatic stop_c();
		sda_drv = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) sda_drv = 1'b0;
		#(2*Q);
	endtask : stop_c

	// data changes only while the clock is low
	task automatic xbit(input logic b, output logic r);
		sda_drv = !b;
		#Q scl = 1'b1;
		#Q r = sda;
		#Q scl = 1'b0;
		#Q;
	endtask : xbit

	// eight bits out or in, then the acknowledge slot
	task automatic xbyte(input logic [7:0] d, input logic ab, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], q[i]);
		end
		xbit(ab, a);
	endtask : xbyte
endmodule : i2c_host_model

// ===== dv/tb_top.sv
// testbench for the secure element host front end
// assumes the host model drives the link; the core side answers each ready with valid
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import sepf_pkg::*;
	logic clk = 0, nrst = 0, rst_pin_n = 1, pend = 0, iface_en = 1, addr_sel = 0, tx_valid = 0;
	logic scl, hsda, sda_out, sda_oe_n, clk_en, pwr_en, asleep, deep, iface, tx_rdy, fwt, a;
	logic [7:0] q, tx_data = 8'h5e, reply_len = 8'h01;
	wire sda = (hsda || !sda_oe_n) ? 1'b0 : 1'b1;
	rx_beat_t rx;
	frame_check_t fc;
	logic [7:0] rxq[$];
	int ok_n = 0, err_n = 0, last_n = 0, tx_n = 0, err_count = 0, checks_done = 0;

	always #5 clk = !clk;

	i2c_host_model u_i2c_host_model (.scl(scl), .sda_drv(hsda), .sda(sda));

	secure_element_i2c_power_front #(.SLEEP_IDLE_CYCLES(4000), .FRAME_WAIT_CYCLES(3000),
		.DEEP_SLEEP_CYCLES(200), .STRAP_HOLD_CYCLES(50)) u_secure_element_i2c_power_front (
		.CLK(clk), .NRST(nrst), .SCL_PIN(scl), .SDA_PIN(sda), .SDA_OUT(sda_out),
		.SDA_OE_N(sda_oe_n), .IFACE_ENABLE_STRAP(iface_en), .ADDR_SELECT_STRAP(addr_sel),
		.RESET_PIN_N(rst_pin_n), .CORE_CLK_EN(clk_en), .CORE_POWER_EN(pwr_en), .ASLEEP(asleep),
		.DEEP_ASLEEP(deep), .IFACE_ACTIVE(iface), .RX(rx), .FRAME_CHK(fc), .REPLY_PENDING(pend),
		.REPLY_LEN(reply_len), .TX_DATA(tx_data), .TX_VALID(tx_valid), .TX_READY(tx_rdy), .FWT_EXPIRED(fwt));

	// collect received bytes, frame verdicts and reply handshakes
	always @(posedge clk) begin
		if (rx.valid === 1'b1) rxq.push_back(rx.data);
		if (rx.last === 1'b1) last_n++;
		if (fc.ok === 1'b1) ok_n++;
		if (fc.err === 1'b1) err_n++;
		if (tx_rdy === 1'b1 && tx_valid === 1'b1) tx_n++;
	end

	// core side: offers the reply byte half a cycle after ready, drops it after the transfer
	always @(negedge clk) tx_valid <= tx_rdy;

	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("FAIL t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk);
	endtask : wait_n

	task automatic send(input logic [7:0] b);
		u_i2c_host_model.xbyte(b, 1'b1, q, a);
		chk(8'(a), 8'h00);
	endtask : send

	task automatic t_write();
		u_i2c_host_model.start_c();
		u_i2c_host_model.xbyte(8'h92, 1'b1, q, a);
		chk(8'(a), 8'h01);
		u_i2c_host_model.start_c();
		send(8'h90);
		send(8'h02);
		send(8'ha5);
		send(8'h3c);
		send(8'h9b);
		u_i2c_host_model.stop_c();
		wait_n(20);
		chk(8'(rxq.size()), 8'h02);
		chk(rxq[1], 8'h3c);
		chk(8'(ok_n), 8'h01);
		chk(8'(last_n), 8'h01);
		wait_n(2780);
		chk(8'(fwt), 8'h00);
		wait_n(300);
		chk(8'(fwt), 8'h01);
		u_i2c_host_model.start_c();
		send(8'h90);
		send(8'h00);
		send(8'h01);
		u_i2c_host_model.stop_c();
		wait_n(20);
		chk(8'(err_n), 8'h01);
		chk(8'(ok_n), 8'h01);
		chk(8'(fwt), 8'h00);
		$display("test write done");
	endtask : t_write

	task automatic t_read();
		@(negedge clk) pend = 1'b1;
		u_i2c_host_model.start_c();
		send(8'h91);
		u_i2c_host_model.xbyte(8'hff, 1'b0, q, a);
		chk(q, 8'h01);
		u_i2c_host_model.xbyte(8'hff, 1'b0, q, a);
		chk(q, 8'h5e);
		u_i2c_host_model.xbyte(8'hff, 1'b1, q, a);
		chk(q, 8'h5f);
		chk(8'(tx_n), 8'h01);
		u_i2c_host_model.stop_c();
		@(negedge clk) pend = 1'b0;
		$display("test read done");
	endtask : t_read

	task automatic t_sleep();
		wait_n(3900);
		chk(8'(asleep), 8'h00);
		wait_n(200);
		chk(8'(asleep), 8'h01);
		chk(8'(clk_en), 8'h00);
		chk(8'(sda_oe_n), 8'h01);
		chk(8'(sda_out), 8'h00);
		u_i2c_host_model.start_c();
		wait_n(10);
		chk(8'(asleep), 8'h00);
		u_i2c_host_model.stop_c();
		$display("test sleep done");
	endtask : t_sleep

	task automatic t_deep();
		@(negedge clk) rst_pin_n = 1'b0;
		addr_sel = 1'b1;
		wait_n(150);
		chk(8'(deep), 8'h00);
		wait_n(100);
		chk(8'(deep), 8'h01);
		chk(8'(pwr_en), 8'h00);
		chk(8'(sda_oe_n), 8'h01);
		rst_pin_n = 1'b1;
		wait_n(70);
		chk(8'(deep), 8'h00);
		chk(8'(iface), 8'h01);
		u_i2c_host_model.start_c();
		u_i2c_host_model.xbyte(8'h90, 1'b1, q, a);
		chk(8'(a), 8'h01);
		u_i2c_host_model.start_c();
		send(8'h92);
		u_i2c_host_model.start_c();
		@(negedge clk) rst_pin_n = 1'b0;
		iface_en = 1'b0;
		wait_n(250);
		chk(8'(deep), 8'h01);
		rst_pin_n = 1'b1;
		wait_n(70);
		chk(8'(iface), 8'h00);
		u_i2c_host_model.stop_c();
		u_i2c_host_model.start_c();
		u_i2c_host_model.xbyte(8'h92, 1'b1, q, a);
		chk(8'(a), 8'h01);
		u_i2c_host_model.stop_c();
		$display("test deep done");
	endtask : t_deep

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done

	// main sequence
	initial begin
		wait_n(5);
		nrst = 1'b1;
		wait_n(60);
		chk(8'(iface), 8'h01);
		chk(8'(clk_en), 8'h01);
		t_write();
		t_read();
		t_sleep();
		t_deep();
		test_done();
	end

	// watchdog
	initial begin
		#400us;
		err_count++;
		test_done();
	end
endmodule : tb_top
